// file: hw/sps_core.sv
// Overview of operation
// - Port uses four lines: data out, data in, shift clock, select.
// - Port is configured as master or slave, single or multi-master systems.
// - As slave, select is the enable; transfers happen only while asserted.
// - Select is always an input; detects several masters in multi-master use.
// - Master never drives select; slaves enabled by a separate output pin.
// - Select asserted while configured as master in a multi-master system flags an error.
// - Shift clock toggles only during a transfer, otherwise idles.
// - All four clock phase and polarity combinations are selectable.
// - As master, drive the clock; shift in from slave line, out on master line.
// - As slave, take the clock in; shift in master line, out slave line.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module sps_core
	import sps_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic irq_out,
	input wire logic port_select_input_n_in,
	input wire logic serial_shift_clock_in,
	output logic serial_shift_clock_out,
	output logic serial_shift_clock_oe_out,
	input wire logic master_to_slave_line_in,
	output logic master_to_slave_line_out,
	output logic master_to_slave_line_oe_out,
	input wire logic slave_to_master_line_in,
	output logic slave_to_master_line_out,
	output logic slave_to_master_line_oe_out,
	output logic slave_select_n_out
);
	import sps_pkg::*;

	logic [SYNC_W-1:0] sy;
	logic sel_act, sclk_s, mosi_s, miso_s, sclk_d_r;
	logic [CTRL_W-1:0] ctrl_r;
	logic [DIV_W-1:0] div_r, tmr_r;
	logic [DATA_W-1:0] tx_hold_r, rx_data_r, tx_sh_r, rx_sh_r;
	logic [ST_W-1:0] stat_r, mask_r, stat_set, stat_clr;
	logic [2:0] bit_cnt_r;
	logic [3:0] edge_cnt_r;
	logic sclk_r, dout_r, pready_r, pslverr_r, irq_r, ss_n_r;
	logic sclk_oe_r, mosi_oe_r, miso_oe_r;
	logic [31:0] prdata_r, rdata;
	sps_state_type state_r;
	logic en, is_master, cpol, cpha, multi;
	logic acc, wr_fire, hit, tx_write, stat_write;
	logic master_start, slave_start, conflict_ev, m_drive, busy;
	logic tick, edge_ev, lead_ev, sample_ev, shift_ev, din, byte_done;

	// Pins are asynchronous to clock_in; select resets to its idle high level.
	sps_sync #(
		.W(SYNC_W),
		.RST(SYNC_RST)
	) u_sync (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.d_in({slave_to_master_line_in, master_to_slave_line_in,
			serial_shift_clock_in, port_select_input_n_in}),
		.q_out(sy)
	);

	assign sel_act = !sy[SY_SEL];
	assign sclk_s = sy[SY_SCLK];
	assign mosi_s = sy[SY_MOSI];
	assign miso_s = sy[SY_MISO];

	assign en = ctrl_r[CTRL_EN];
	assign is_master = ctrl_r[CTRL_MASTER];
	assign cpol = ctrl_r[CTRL_CPOL];
	assign cpha = ctrl_r[CTRL_CPHA];
	assign multi = ctrl_r[CTRL_MULTI];
	assign busy = (state_r != SPS_IDLE);

	// APB: one wait state, so read data always comes out of a register.
	assign acc = psel_in && penable_in && !pready_r;
	assign wr_fire = psel_in && penable_in && pready_r && pwrite_in;
	assign tx_write = wr_fire && (paddr_in == ADDR_TX);
	assign stat_write = wr_fire && (paddr_in == ADDR_STAT);

	always_comb begin
		hit = 1'b1;
		rdata = 32'h0000_0000;
		unique case (paddr_in)
			ADDR_CTRL: rdata = 32'(ctrl_r);
			ADDR_DIV: rdata = 32'(div_r);
			ADDR_TX: rdata = 32'(tx_hold_r);
			ADDR_RX: rdata = 32'(rx_data_r);
			ADDR_STAT: rdata = 32'({busy, stat_r});
			ADDR_MASK: rdata = 32'(mask_r);
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= acc;
			pslverr_r <= acc && !hit;
			prdata_r <= (acc && !pwrite_in && hit) ? rdata : 32'h0000_0000;
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ctrl_r <= CTRL_RST;
			div_r <= DIV_RST;
			mask_r <= MASK_RST;
			tx_hold_r <= '0;
		end else if (wr_fire) begin
			unique case (paddr_in)
				ADDR_CTRL: ctrl_r <= pwdata_in[CTRL_W-1:0];
				ADDR_DIV: div_r <= pwdata_in[DIV_W-1:0];
				ADDR_MASK: mask_r <= pwdata_in[ST_W-1:0];
				ADDR_TX: tx_hold_r <= pwdata_in[DATA_W-1:0];
				default: ;
			endcase
		end
	end

	// Select seen while master in a multi-master system means another master
	// is active; a single-master system leaves the select pin unused.
	assign conflict_ev = en && is_master && multi && sel_act;
	// Master drivers stay off until software clears the conflict flag.
	assign m_drive = en && is_master && !stat_r[ST_CONFLICT] && !conflict_ev;
	assign master_start = tx_write && (state_r == SPS_IDLE) && m_drive;
	assign slave_start = (state_r == SPS_IDLE) && en && !is_master && sel_act;

	// Master clock generator.
	assign tick = (state_r == SPS_MASTER) && (tmr_r == '0);

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			tmr_r <= DIV_RST;
			edge_cnt_r <= 4'h0;
			sclk_r <= 1'b0;
		end else if (state_r != SPS_MASTER) begin
			tmr_r <= div_r;
			edge_cnt_r <= 4'h0;
			sclk_r <= cpol;
		end else if (tick) begin
			tmr_r <= div_r;
			edge_cnt_r <= edge_cnt_r + 4'h1;
			sclk_r <= !sclk_r;
		end else begin
			tmr_r <= tmr_r - 8'h01;
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk_s;
		end
	end

	// A leading edge leaves the idle level; phase picks which edge samples.
	always_comb begin
		if (state_r == SPS_MASTER) begin
			edge_ev = tick;
			lead_ev = !edge_cnt_r[0];
			din = miso_s;
		end else begin
			edge_ev = (state_r == SPS_SLAVE) && (sclk_s != sclk_d_r);
			lead_ev = (sclk_s != cpol);
			din = mosi_s;
		end
	end
	assign sample_ev = edge_ev && (lead_ev ^ cpha);
	assign shift_ev = edge_ev && !(lead_ev ^ cpha);
	assign byte_done = sample_ev && (bit_cnt_r == LAST_BIT);

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state_r <= SPS_IDLE;
		end else begin
			unique case (state_r)
				SPS_IDLE: begin
					if (master_start) begin
						state_r <= SPS_MASTER;
					end else if (slave_start) begin
						state_r <= SPS_SLAVE;
					end
				end
				SPS_MASTER: begin
					if (conflict_ev || !en) begin
						state_r <= SPS_IDLE;
					end else if (tick && edge_cnt_r == LAST_EDGE) begin
						state_r <= SPS_IDLE;
					end
				end
				SPS_SLAVE: begin
					if (!sel_act || !en || is_master) begin
						state_r <= SPS_IDLE;
					end
				end
				default: state_r <= SPS_IDLE;
			endcase
		end
	end

	// Shift data path shared by both roles; dout_r is the serial output bit.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			tx_sh_r <= '0;
			dout_r <= 1'b0;
		end else if (master_start || slave_start) begin
			if (!cpha) begin
				dout_r <= master_start ? pwdata_in[DATA_W-1] : tx_hold_r[DATA_W-1];
				tx_sh_r <= (master_start ? pwdata_in[DATA_W-1:0] : tx_hold_r) << 1;
			end else begin
				tx_sh_r <= master_start ? pwdata_in[DATA_W-1:0] : tx_hold_r;
			end
		end else if (byte_done && state_r == SPS_SLAVE) begin
			// Slave keeps answering with the held byte for each further byte.
			tx_sh_r <= tx_hold_r;
		end else if (shift_ev) begin
			dout_r <= tx_sh_r[DATA_W-1];
			tx_sh_r <= tx_sh_r << 1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rx_sh_r <= '0;
			rx_data_r <= '0;
			bit_cnt_r <= 3'h0;
		end else if (master_start || slave_start) begin
			bit_cnt_r <= 3'h0;
		end else if (sample_ev) begin
			rx_sh_r <= {rx_sh_r[DATA_W-2:0], din};
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (byte_done) begin
				rx_data_r <= {rx_sh_r[DATA_W-2:0], din};
			end
		end
	end

	// Sticky status: a set in the same cycle as a clear wins.
	assign stat_set = {conflict_ev, byte_done};
	assign stat_clr = stat_write ? pwdata_in[ST_W-1:0] : '0;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			stat_r <= ST_RST;
			irq_r <= 1'b0;
		end else begin
			stat_r <= (stat_r & ~stat_clr) | stat_set;
			irq_r <= |(stat_r & mask_r);
		end
	end

	// Pin drivers. Select has no output; slaves are picked by a plain pin.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			sclk_oe_r <= 1'b0;
			mosi_oe_r <= 1'b0;
			miso_oe_r <= 1'b0;
			ss_n_r <= 1'b1;
		end else begin
			sclk_oe_r <= m_drive;
			mosi_oe_r <= m_drive;
			miso_oe_r <= en && !is_master && sel_act;
			ss_n_r <= !ctrl_r[CTRL_SS];
		end
	end

	assign prdata_out = prdata_r;
	assign pready_out = pready_r;
	assign pslverr_out = pslverr_r;
	assign irq_out = irq_r;
	assign serial_shift_clock_out = sclk_r;
	assign serial_shift_clock_oe_out = sclk_oe_r;
	assign master_to_slave_line_out = dout_r;
	assign master_to_slave_line_oe_out = mosi_oe_r;
	assign slave_to_master_line_out = dout_r;
	assign slave_to_master_line_oe_out = miso_oe_r;
	assign slave_select_n_out = ss_n_r;

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	sequence m_start_s;
		master_start;
	endsequence

	sequence m_idle_level_s;
		(state_r == SPS_MASTER) && (serial_shift_clock_out == cpol);
	endsequence

	apb_wait_a: assert property (acc |=> pready_out)
		else $error("APB access not answered after one wait state");

	irq_level_a: assert property (|(stat_r & mask_r) |=> irq_out)
		else $error("Interrupt not raised for unmasked status");

	conflict_flag_a: assert property (conflict_ev |=> stat_r[ST_CONFLICT])
		else $error("Select conflict not flagged");

	conflict_abort_a: assert property (conflict_ev |=>
		state_r == SPS_IDLE && !master_to_slave_line_oe_out && !serial_shift_clock_oe_out)
		else $error("Master kept driving after select conflict");

	select_pin_a: assert property (ctrl_r[CTRL_SS] |=> !slave_select_n_out)
		else $error("Slave select pin does not follow its control bit");

	slave_drive_a: assert property (slave_to_master_line_oe_out |->
		$past(sel_act && en && !is_master))
		else $error("Slave line driven without select");

	master_pins_a: assert property (m_drive |=>
		serial_shift_clock_oe_out && master_to_slave_line_oe_out
		&& !slave_to_master_line_oe_out)
		else $error("Master pin drivers wrong");

	slave_clock_a: assert property (en && !is_master |=>
		!serial_shift_clock_oe_out && !master_to_slave_line_oe_out)
		else $error("Slave drives clock or master line");

	frame_start_a: assert property (m_start_s |=> m_idle_level_s ##1
		(serial_shift_clock_out == cpol))
		else $error("Shift clock left idle level too early");

	clock_gate_a: assert property ($fell(busy) && !$past(conflict_ev)
		|-> serial_shift_clock_out == cpol)
		else $error("Shift clock not idle after frame");

	byte_done_a: assert property (byte_done |=> stat_r[ST_DONE]
		&& rx_data_r == $past({rx_sh_r[DATA_W-2:0], din}))
		else $error("Received byte not stored on eighth bit");
endmodule
`default_nettype wire

// file: hw/sps_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sps_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_r;
			// The first stage feeds only the second one.
			always_ff @(posedge clock_in) begin
				if (rst_in) begin
					meta_r <= RST[i];
					q_out[i] <= RST[i];
				end else begin
					meta_r <= d_in[i];
					q_out[i] <= meta_r;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// file: include/sps_pkg.sv
package sps_pkg;
	// Register byte offsets on the APB.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DIV = 8'h04;
	localparam logic [7:0] ADDR_TX = 8'h08;
	localparam logic [7:0] ADDR_RX = 8'h0c;
	localparam logic [7:0] ADDR_STAT = 8'h10;
	localparam logic [7:0] ADDR_MASK = 8'h14;

	// Control register fields.
	localparam int CTRL_W = 6;
	localparam int CTRL_EN = 0;
	localparam int CTRL_MASTER = 1;
	localparam int CTRL_CPOL = 2;
	localparam int CTRL_CPHA = 3;
	localparam int CTRL_MULTI = 4;
	localparam int CTRL_SS = 5;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

	// Half period of the master shift clock is DIV + 1 clock cycles.
	localparam int DIV_W = 8;
	localparam logic [DIV_W-1:0] DIV_RST = 8'h03;

	// Sticky status bits, mask of the same layout, busy read-only above them.
	localparam int ST_W = 2;
	localparam int ST_DONE = 0;
	localparam int ST_CONFLICT = 1;
	localparam int ST_BUSY = 2;
	localparam logic [ST_W-1:0] ST_RST = 2'h0;
	localparam logic [ST_W-1:0] MASK_RST = 2'h0;

	localparam int DATA_W = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [3:0] LAST_EDGE = 4'hf;

	// Synchroniser lanes for the pins.
	localparam int SYNC_W = 4;
	localparam int SY_SEL = 0;
	localparam int SY_SCLK = 1;
	localparam int SY_MOSI = 2;
	localparam int SY_MISO = 3;
	localparam logic [SYNC_W-1:0] SYNC_RST = 4'h1;

	typedef enum logic [1:0] {
		SPS_IDLE = 2'b00,
		SPS_MASTER = 2'b01,
		SPS_SLAVE = 2'b10
	} sps_state_type;
endpackage

// file: verif/spi_pin_behaviour_bench.sv
`timescale 1ns/10ps
`default_nettype none
module spi_pin_behaviour_bench;
	import sps_pkg::*;
	logic clock_in, rst_in, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0] paddr, m_got, got;
	logic [31:0] pwdata, prdata, rd, ctrl;
	logic sel_n, tb_sclk, tb_mosi, cpol, cpha;
	logic [7:0] reply_sel;
	logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n, m_miso;
	int num_errors, check_count, cyc;
	wire sclk_w = sclk_oe ? sclk_o : tb_sclk;
	wire mosi_w = mosi_oe ? mosi_o : tb_mosi;
	wire miso_w = miso_oe ? miso_o : m_miso;
	// Mode in bits 17:16 (cpol, cpha), byte sent, byte the far end replies.
	localparam logic [17:0] ROWS [4] = '{18'h0a53c, 18'h1815a, 18'h27ec3, 18'h30180};
	sps_core DUT (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
		.port_select_input_n_in(sel_n), .serial_shift_clock_in(sclk_w),
		.serial_shift_clock_out(sclk_o), .serial_shift_clock_oe_out(sclk_oe),
		.master_to_slave_line_in(mosi_w), .master_to_slave_line_out(mosi_o),
		.master_to_slave_line_oe_out(mosi_oe), .slave_to_master_line_in(miso_w),
		.slave_to_master_line_out(miso_o), .slave_to_master_line_oe_out(miso_oe),
		.slave_select_n_out(ss_n));
	sps_slave_model far_end (.sel_n_in(ss_n), .sclk_in(sclk_w), .mosi_in(mosi_w),
		.cpol_in(cpol), .cpha_in(cpha), .reply_in(reply_sel), .miso_out(m_miso),
		.got_out(m_got));
	initial begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		do begin
			@(posedge clock_in);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (pready !== 1'b1) begin
			num_errors++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, ADDR_STAT, 32'h0);
			n++;
		end while (rd[ST_BUSY] !== 1'b0 && n < 100);
		if (rd[ST_BUSY] !== 1'b0) begin
			num_errors++;
		end
	endtask
	// The bench plays master on the pins: 400 ns shift clock period, mode zero.
	task automatic drive_frame(input logic [7:0] b);
		@(posedge clock_in);
		sel_n <= 1'b0;
		repeat (8) @(posedge clock_in);
		chk(miso_oe, 1'b1);
		for (int i = 7; i >= 0; i--) begin
			tb_mosi <= b[i];
			repeat (4) @(posedge clock_in);
			tb_sclk <= 1'b1;
			got = {got[6:0], miso_w};
			repeat (4) @(posedge clock_in);
			tb_sclk <= 1'b0;
		end
		repeat (8) @(posedge clock_in);
		sel_n <= 1'b1;
		tb_mosi <= ~tb_mosi;
	endtask
	initial begin
		rst_in = 1'b1;
		{psel, penable, pwrite, tb_sclk, tb_mosi, cpol, cpha} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		sel_n = 1'b1;
		repeat (12) @(posedge clock_in);
		chk(ss_n, 1'b1);
		chk({sclk_oe, mosi_oe, miso_oe, irq}, 4'h0);
		rst_in <= 1'b0;
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, CTRL_RST);
		apb(1'b0, ADDR_DIV, 32'h0);
		chk(rd, DIV_RST);
		apb(1'b0, ADDR_STAT, 32'h0);
		chk(rd, ST_RST);
		apb(1'b0, ADDR_MASK, 32'h0);
		chk(rd, MASK_RST);
		apb(1'b0, 8'h18, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		$display("reset and register test done");
		apb(1'b1, ADDR_MASK, 32'h1 << ST_DONE);
		for (int i = 0; i < 4; i++) begin
			{cpol, cpha} = ROWS[i][17:16];
			force_reply(ROWS[i][7:0]);
			ctrl = (1 << CTRL_EN) | (1 << CTRL_MASTER);
			ctrl = ctrl | (32'(cpol) << CTRL_CPOL) | (32'(cpha) << CTRL_CPHA);
			// The mode changes while the far end is deselected, so it sees no stray edge.
			apb(1'b1, ADDR_CTRL, ctrl);
			repeat (2) @(posedge clock_in);
			chk(sclk_w, cpol);
			apb(1'b1, ADDR_CTRL, ctrl | (32'h1 << CTRL_SS));
			apb(1'b1, ADDR_TX, {24'h0, ROWS[i][15:8]});
			chk(ss_n, 1'b0);
			wait_idle();
			chk(sclk_w, cpol);
			chk(m_got, ROWS[i][15:8]);
			apb(1'b0, ADDR_RX, 32'h0);
			chk(rd, {24'h0, ROWS[i][7:0]});
			chk(irq, 1'b1);
			apb(1'b1, ADDR_STAT, 32'h1 << ST_DONE);
			apb(1'b0, ADDR_STAT, 32'h0);
			chk(irq, 1'b0);
			apb(1'b1, ADDR_CTRL, ctrl);
		end
		$display("master mode rows done");
		apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_EN);
		apb(1'b1, ADDR_TX, 32'h96);
		tb_sclk <= 1'b1;
		repeat (8) @(posedge clock_in);
		tb_sclk <= 1'b0;
		chk(miso_oe, 1'b0);
		drive_frame(8'h69);
		chk(got, 8'h96);
		apb(1'b0, ADDR_RX, 32'h0);
		chk(rd, 32'h69);
		$display("slave test done");
		apb(1'b1, ADDR_MASK, 32'h1 << ST_CONFLICT);
		apb(1'b1, ADDR_CTRL, (1 << CTRL_EN) | (1 << CTRL_MASTER) | (1 << CTRL_MULTI));
		apb(1'b1, ADDR_TX, 32'hff);
		repeat (10) @(posedge clock_in);
		sel_n <= 1'b0;
		repeat (10) @(posedge clock_in);
		chk({sclk_oe, mosi_oe, irq}, 3'h1);
		apb(1'b0, ADDR_STAT, 32'h0);
		chk(rd[ST_CONFLICT], 1'b1);
		sel_n <= 1'b1;
		apb(1'b1, ADDR_STAT, 32'h1 << ST_CONFLICT);
		apb(1'b0, ADDR_STAT, 32'h0);
		chk({rd[ST_CONFLICT], irq}, 2'h0);
		$display("conflict test done");
		tally_and_finish();
	end
	task automatic force_reply(input logic [7:0] b);
		reply_sel = b;
	endtask
endmodule
`default_nettype wire

// file: verif/sps_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module sps_slave_model (
	input wire logic sel_n_in,
	input wire logic sclk_in,
	input wire logic mosi_in,
	input wire logic cpol_in,
	input wire logic cpha_in,
	input wire logic [7:0] reply_in,
	output logic miso_out,
	output logic [7:0] got_out
);
	logic [7:0] shift_r;
	initial begin
		miso_out = 1'b0;
		got_out = 8'h00;
		shift_r = 8'h00;
	end
	// Bit 7 is ready at select so a phase zero master can sample it on the first edge.
	always @(negedge sel_n_in) begin
		shift_r = reply_in;
		miso_out = reply_in[7];
	end
	// A released line shows the inverse of its last value, never a stale copy.
	always @(posedge sel_n_in) begin
		miso_out = ~miso_out;
	end
	always @(sclk_in) begin
		if (!sel_n_in) begin
			if ((sclk_in != cpol_in) != cpha_in) begin
				got_out = {got_out[6:0], mosi_in};
			end else if (cpha_in) begin
				miso_out = shift_r[7];
				shift_r = shift_r << 1;
			end else begin
				shift_r = shift_r << 1;
				miso_out = shift_r[7];
			end
		end
	end
endmodule
`default_nettype wire
